// ### rtl/p2dlc_consts.vh
// constants for the second-stage pll divider and loop filter configuration block
// assumes a byte-wide register port and one 25 MHz system clock
`ifndef P2DLC_CONSTS_VH
`define P2DLC_CONSTS_VH

`define P2DLC_ADDR_W          10
`define P2DLC_OFS_LOOP_LOW    10'h205
`define P2DLC_OFS_LOOP_HIGH   10'h206
`define P2DLC_OFS_REF_DIV     10'h207
`define P2DLC_OFS_FB_DIV      10'h208
`define P2DLC_OFS_FB_PHASE    10'h209

`define P2DLC_MASK_LOOP_LOW   8'hff
`define P2DLC_MASK_LOOP_HIGH  8'h01
`define P2DLC_MASK_REF_DIV    8'h1f
`define P2DLC_MASK_FB_DIV     8'hff
`define P2DLC_MASK_FB_PHASE   8'h7f

`define P2DLC_RST_LOOP_LOW    8'h00
`define P2DLC_RST_LOOP_HIGH   8'h00
`define P2DLC_RST_REF_DIV     8'h00
`define P2DLC_RST_FB_DIV      8'h00
`define P2DLC_RST_FB_PHASE    8'h00
`define P2DLC_RST_ZERO_OHMS   12'hcb2

`define P2DLC_POLE_LSB        0
`define P2DLC_ZERO_LSB        3
`define P2DLC_RPOLE2_LSB      6
`define P2DLC_BYPASS_BIT      0
`define P2DLC_FB_PD_BIT       6

`define P2DLC_VCO_DIV3        3'h3
`define P2DLC_VCO_DIV4        3'h4
`define P2DLC_VCO_DIV5        3'h5
`define P2DLC_CNT_W           9

`endif

// ### rtl/p2dlc_div.v
// p2dlc_div: tick-counting modulo divider with a start delay after sync
// assumes i_tick is a one-cycle pulse synchronous to i_clock
`timescale 1ns/1ns
`include "p2dlc_consts.vh"
module p2dlc_div (
    input  wire                    i_clock,
    input  wire                    i_rst_n,
    input  wire                    i_enable,
    input  wire                    i_sync,
    input  wire                    i_tick,
    input  wire [`P2DLC_CNT_W-1:0] i_modulus_m1,
    input  wire [5:0]              i_delay,
    output reg                     o_pulse
);
    reg [`P2DLC_CNT_W-1:0] count_r;
    reg [5:0]              delay_r;

    // sync restarts the count; delay ticks are swallowed before counting resumes
    always @(posedge i_clock) begin
        if (!i_rst_n || !i_enable) begin
            count_r <= {`P2DLC_CNT_W{1'b0}};
            delay_r <= 6'h00;
            o_pulse <= 1'b0;
        end else if (i_sync) begin
            count_r <= {`P2DLC_CNT_W{1'b0}};
            delay_r <= i_delay;
            o_pulse <= 1'b0;
        end else begin
            o_pulse <= 1'b0;
            if (i_tick) begin
                if (delay_r != 6'h00) begin
                    delay_r <= delay_r - 6'h01;
                end else if (count_r >= i_modulus_m1) begin
                    count_r <= {`P2DLC_CNT_W{1'b0}}; // >= guards a modulus shrunk mid-count
                    o_pulse <= 1'b1;
                end else begin
                    count_r <= count_r + {{(`P2DLC_CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // p2dlc_div

// ### rtl/p2dlc_top.v
// p2dlc_top: register file and dividers for the second-stage pll
// assumes reference and vco edges arrive as one-cycle tick pulses on i_clock
`timescale 1ns/1ns
`include "p2dlc_consts.vh"
module p2dlc_top (
    input  wire                     i_clock,
    input  wire                     i_rst_n,
    // byte register port; each strobe is a one-cycle pulse
    input  wire [`P2DLC_ADDR_W-1:0] i_reg_addr,
    input  wire [7:0]               i_reg_wdata,
    input  wire                     i_reg_wr,
    input  wire                     i_reg_rd,
    output reg  [7:0]               o_reg_rdata,
    output reg                      o_reg_rvalid,
    // input edges arrive as one-cycle ticks; vco divider controls are plain levels
    input  wire                     i_ref_tick,
    input  wire                     i_vco_half_tick,
    input  wire [2:0]               i_vco_output_divider_ratio,
    input  wire                     i_vco_output_divider_pd,
    input  wire                     i_sync,
    // phase detector ticks, one cycle wide
    output wire                     o_ref_pfd_tick,
    output wire                     o_fb_pfd_tick,
    // loop filter selects and feedback power-down, all registered
    output reg                      o_feedback_divider_pd,
    output reg  [11:0]              o_loop_zero_resistor_ohms,
    output reg                      o_loop_zero_bypass,
    output reg  [5:0]               o_loop_pole_capacitor_pf,
    output reg  [1:0]               o_loop_pole2_code
);
    reg [7:0] loop_low_r;
    reg [7:0] loop_high_r;
    reg [7:0] ref_div_r;
    reg [7:0] fb_div_r;
    reg [7:0] fb_phase_r;

    wire [`P2DLC_CNT_W-1:0] ref_mod_m1;
    wire [`P2DLC_CNT_W-1:0] vco_mod_m1;
    wire [`P2DLC_CNT_W-1:0] fb_mod_m1;
    wire                    vco_half_pulse;
    wire                    fb_enable;
    wire [4:0]              acc_sel;

    // one-hot register selects; an unmapped offset selects nothing
    localparam [4:0] SEL_NONE      = 5'h00;
    localparam [4:0] SEL_LOOP_LOW  = 5'h01;
    localparam [4:0] SEL_LOOP_HIGH = 5'h02;
    localparam [4:0] SEL_REF_DIV   = 5'h04;
    localparam [4:0] SEL_FB_DIV    = 5'h08;
    localparam [4:0] SEL_FB_PHASE  = 5'h10;

    // resistor code to ohms
    function [11:0] zero_ohms;
        input [2:0] code;
        begin
            case (code)
                3'h0: zero_ohms = 12'hcb2; // 3250
                3'h1: zero_ohms = 12'habe; // 2750
                3'h2: zero_ohms = 12'h8ca; // 2250
                3'h3: zero_ohms = 12'h834; // 2100
                3'h4: zero_ohms = 12'hbb8; // 3000
                3'h5: zero_ohms = 12'h9c4; // 2500
                3'h6: zero_ohms = 12'h7d0; // 2000
                default: zero_ohms = 12'h73a; // 1850
            endcase
        end
    endfunction

    // capacitor code to picofarads; codes 3 and 4 are both 24 pF
    function [5:0] pole_pf;
        input [2:0] code;
        begin
            case (code)
                3'h0: pole_pf = 6'h00;
                3'h1: pole_pf = 6'h08;
                3'h2: pole_pf = 6'h10;
                3'h3: pole_pf = 6'h18;
                3'h4: pole_pf = 6'h18;
                3'h5: pole_pf = 6'h20;
                3'h6: pole_pf = 6'h28;
                default: pole_pf = 6'h30;
            endcase
        end
    endfunction

    // vco divider ratio minus one; unsupported codes fall back to divide by 3
    function [`P2DLC_CNT_W-1:0] vco_m1;
        input [2:0] code;
        begin
            case (code)
                `P2DLC_VCO_DIV4: vco_m1 = 9'h003;
                `P2DLC_VCO_DIV5: vco_m1 = 9'h004;
                default:         vco_m1 = 9'h002;
            endcase
        end
    endfunction

    // offset decode shared by the write and read paths
    function [4:0] reg_sel;
        input [`P2DLC_ADDR_W-1:0] addr;
        begin
            case (addr)
                `P2DLC_OFS_LOOP_LOW:  reg_sel = SEL_LOOP_LOW;
                `P2DLC_OFS_LOOP_HIGH: reg_sel = SEL_LOOP_HIGH;
                `P2DLC_OFS_REF_DIV:   reg_sel = SEL_REF_DIV;
                `P2DLC_OFS_FB_DIV:    reg_sel = SEL_FB_DIV;
                `P2DLC_OFS_FB_PHASE:  reg_sel = SEL_FB_PHASE;
                default:              reg_sel = SEL_NONE;
            endcase
        end
    endfunction

    // unmapped offsets decode to no select, so they neither write nor read back
    assign acc_sel = reg_sel(i_reg_addr);

    // register writes keep only defined bits, so reserved bits stay zero
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            loop_low_r  <= `P2DLC_RST_LOOP_LOW;
            loop_high_r <= `P2DLC_RST_LOOP_HIGH;
            ref_div_r   <= `P2DLC_RST_REF_DIV;
            fb_div_r    <= `P2DLC_RST_FB_DIV;
            fb_phase_r  <= `P2DLC_RST_FB_PHASE;
        end else if (i_reg_wr) begin
            if (acc_sel == SEL_LOOP_LOW) begin
                loop_low_r <= i_reg_wdata & `P2DLC_MASK_LOOP_LOW;
            end
            if (acc_sel == SEL_LOOP_HIGH) begin
                loop_high_r <= i_reg_wdata & `P2DLC_MASK_LOOP_HIGH;
            end
            if (acc_sel == SEL_REF_DIV) begin
                ref_div_r <= i_reg_wdata & `P2DLC_MASK_REF_DIV;
            end
            if (acc_sel == SEL_FB_DIV) begin
                fb_div_r <= i_reg_wdata & `P2DLC_MASK_FB_DIV;
            end
            if (acc_sel == SEL_FB_PHASE) begin
                fb_phase_r <= i_reg_wdata & `P2DLC_MASK_FB_PHASE;
            end
        end
    end

    // readback one cycle after the strobe; unmapped offsets answer zero
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                case (acc_sel)
                    SEL_LOOP_LOW:  o_reg_rdata <= loop_low_r;
                    SEL_LOOP_HIGH: o_reg_rdata <= loop_high_r;
                    SEL_REF_DIV:   o_reg_rdata <= ref_div_r;
                    SEL_FB_DIV:    o_reg_rdata <= fb_div_r;
                    SEL_FB_PHASE:  o_reg_rdata <= fb_phase_r;
                    default:       o_reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // loop filter analog selects, registered so the outputs come from flops
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_loop_zero_resistor_ohms <= `P2DLC_RST_ZERO_OHMS;
            o_loop_zero_bypass        <= 1'b0;
            o_loop_pole_capacitor_pf  <= 6'h00;
            o_loop_pole2_code         <= 2'h0;
            o_feedback_divider_pd     <= 1'b0;
        end else begin
            o_loop_zero_resistor_ohms <= zero_ohms(loop_low_r[`P2DLC_ZERO_LSB+:3]);
            o_loop_zero_bypass        <= loop_high_r[`P2DLC_BYPASS_BIT];
            o_loop_pole_capacitor_pf  <= pole_pf(loop_low_r[`P2DLC_POLE_LSB+:3]);
            o_loop_pole2_code         <= loop_low_r[`P2DLC_RPOLE2_LSB+:2];
            o_feedback_divider_pd     <= fb_phase_r[`P2DLC_FB_PD_BIT];
        end
    end

    // codes 0 and 1 both give a modulus of one
    assign ref_mod_m1 = (ref_div_r[4:0] <= 5'h01) ? 9'h000 :
                        {4'h0, ref_div_r[4:0] - 5'h01};
    // vco half ticks: one output half period every ratio half ticks
    assign vco_mod_m1 = vco_m1(i_vco_output_divider_ratio);
    // feedback counts half periods, so its modulus is twice (code + 1)
    assign fb_mod_m1  = {fb_div_r, 1'b1};
    assign fb_enable  = !fb_phase_r[`P2DLC_FB_PD_BIT];

    // divider chain: ref ticks -> u_ref_div -> o_ref_pfd_tick, and
    // vco half ticks -> u_vco_div -> u_fb_div -> o_fb_pfd_tick;
    // u_vco_div pulses once per half period of the vco divider output,
    // so u_fb_div counts 2*(code+1) of them per feedback period.
    // sync restarts all three from zero so their phases realign;
    // a new phase code only takes effect at the next sync
    p2dlc_div u_ref_div (
        .i_clock      (i_clock),
        .i_rst_n      (i_rst_n),
        .i_enable     (1'b1),
        .i_sync       (i_sync),
        .i_tick       (i_ref_tick),
        .i_modulus_m1 (ref_mod_m1),
        .i_delay      (6'h00),
        .o_pulse      (o_ref_pfd_tick)
    );

    // vco output divider feeding the feedback divider; stopped when powered down
    p2dlc_div u_vco_div (
        .i_clock      (i_clock),
        .i_rst_n      (i_rst_n),
        .i_enable     (!i_vco_output_divider_pd),
        .i_sync       (i_sync),
        .i_tick       (i_vco_half_tick),
        .i_modulus_m1 (vco_mod_m1),
        .i_delay      (6'h00),
        .o_pulse      (vco_half_pulse)
    );

    // phase delay is counted in half periods of the vco divider output
    p2dlc_div u_fb_div (
        .i_clock      (i_clock),
        .i_rst_n      (i_rst_n),
        .i_enable     (fb_enable),
        .i_sync       (i_sync),
        .i_tick       (vco_half_pulse),
        .i_modulus_m1 (fb_mod_m1),
        .i_delay      (fb_phase_r[5:0]),
        .o_pulse      (o_fb_pfd_tick)
    );
endmodule // p2dlc_top

// ### bench/p2dlc_sva.sv
// checker: port-level assertions for the pll2 divider block
// assumes it is bound into p2dlc_top and sees only its ports
`timescale 1ns/1ns
module p2dlc_sva (
    input wire        i_clock,
    input wire        i_rst_n,
    input wire [9:0]  i_reg_addr,
    input wire [7:0]  i_reg_wdata,
    input wire        i_reg_wr,
    input wire        i_reg_rd,
    input wire [7:0]  o_reg_rdata,
    input wire        o_reg_rvalid,
    input wire        i_vco_output_divider_pd,
    input wire        o_fb_pfd_tick,
    input wire        o_feedback_divider_pd,
    input wire [11:0] o_loop_zero_resistor_ohms,
    input wire        o_loop_zero_bypass,
    input wire [5:0]  o_loop_pole_capacitor_pf
);
    localparam logic [5:0]  PF [8] = '{0, 8, 16, 24, 24, 32, 40, 48};
    localparam logic [11:0] OH [8] = '{3250, 2750, 2250, 2100, 3000, 2500, 2000, 1850};
    // writes reach the analog outputs two edges later, so checks look back two
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence wr_at(logic [9:0] a);
        i_reg_wr && i_reg_addr == a;
    endsequence
    sequence rd_hole;
        i_reg_rd && (i_reg_addr < 10'h205 || i_reg_addr > 10'h209);
    endsequence
    read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid) else $error("no read answer");
    rvalid_pulse_a: assert property (!i_reg_rd |=> !o_reg_rvalid) else $error("stray rvalid");
    hole_reads_zero_a: assert property (rd_hole |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    reserved_zero_a: assert property (i_reg_rd && i_reg_addr == 10'h206 |=> o_reg_rdata[7:1] == 7'h00)
        else $error("reserved bits not zero");
    bypass_follow_a: assert property (wr_at(10'h206) |-> ##2 o_loop_zero_bypass == $past(i_reg_wdata[0], 2))
        else $error("bypass wrong");
    pole_cap_map_a: assert property (wr_at(10'h205) |-> ##2 o_loop_pole_capacitor_pf == PF[$past(i_reg_wdata[2:0], 2)])
        else $error("pole cap wrong");
    zero_res_map_a: assert property (wr_at(10'h205) |-> ##2 o_loop_zero_resistor_ohms == OH[$past(i_reg_wdata[5:3], 2)])
        else $error("zero res wrong");
    fb_pd_copy_a: assert property (wr_at(10'h209) |-> ##2 o_feedback_divider_pd == $past(i_reg_wdata[6], 2))
        else $error("fb pd wrong");
    fb_pd_quiet_a: assert property (o_feedback_divider_pd [*2] |-> !o_fb_pfd_tick)
        else $error("fb pulse while down");
    vco_stop_quiet_a: assert property (i_vco_output_divider_pd [*8] |-> !o_fb_pfd_tick)
        else $error("fb pulse with vco div stopped");
endmodule // p2dlc_sva
bind p2dlc_top p2dlc_sva u_p2dlc_sva (.i_clock, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_vco_output_divider_pd, .o_fb_pfd_tick,
    .o_feedback_divider_pd, .o_loop_zero_resistor_ohms, .o_loop_zero_bypass,
    .o_loop_pole_capacitor_pf);

// ### bench/tb_top.sv
// testbench: register and divider sequences for the pll2 divider block
// assumes the byte register port and a tick on every second clock
`timescale 1ns/1ns
module tb_top;
    logic        i_clock, i_rst_n, i_reg_wr, i_reg_rd, i_sync, i_vco_output_divider_pd;
    logic        o_reg_rvalid, o_ref_pfd_tick, o_fb_pfd_tick, o_feedback_divider_pd;
    logic        o_loop_zero_bypass;
    logic [9:0]  i_reg_addr;
    logic [7:0]  i_reg_wdata, o_reg_rdata;
    logic [2:0]  i_vco_output_divider_ratio;
    logic [11:0] o_loop_zero_resistor_ohms;
    logic [5:0]  o_loop_pole_capacitor_pf;
    logic [1:0]  o_loop_pole2_code;
    logic [15:0] cyc = 16'h0000;
    int          n_fail, compares, d0, n, k;
    int pf[8] = '{0, 8, 16, 24, 24, 32, 40, 48};
    int oh[8] = '{3250, 2750, 2250, 2100, 3000, 2500, 2000, 1850};
    int msk[6] = '{255, 1, 31, 255, 127, 0};
    int rc[4] = '{0, 1, 2, 31};
    int fn[6] = '{0, 1, 255, 1, 1, 1};
    int fm[6] = '{3, 3, 3, 4, 5, 7};
    int ph[3] = '{0, 1, 63};
    p2dlc_top u_p2dlc_top (.i_clock, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
        .o_reg_rdata, .o_reg_rvalid, .i_ref_tick(cyc[0]), .i_vco_half_tick(cyc[0]),
        .i_vco_output_divider_ratio, .i_vco_output_divider_pd, .i_sync, .o_ref_pfd_tick,
        .o_fb_pfd_tick, .o_feedback_divider_pd, .o_loop_zero_resistor_ohms,
        .o_loop_zero_bypass, .o_loop_pole_capacitor_pf, .o_loop_pole2_code);
    task close_out;
        if (n_fail == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input bit ok);
        compares++;
        if (!ok) begin
            n_fail++;
            $display("CHECK FAILED at %0t: mismatch", $time);
        end
    endtask
    task wr(input [9:0] a, input [7:0] d);
        @(negedge i_clock);
        {i_reg_addr, i_reg_wdata, i_reg_wr} = {a, d, 1'b1};
        @(negedge i_clock);
        i_reg_wr = 0;
    endtask
    task rd(input [9:0] a, input [7:0] e);
        @(negedge i_clock);
        {i_reg_addr, i_reg_rd} = {a, 1'b1};
        @(negedge i_clock);
        i_reg_rd = 0;
        chk(o_reg_rvalid === 1'b1 && o_reg_rdata === e);
    endtask
    // sync always lands on the same tick phase so delays compare exactly
    task do_sync;
        repeat (2) @(negedge i_clock);
        if (cyc[0]) @(negedge i_clock);
        i_sync = 1;
        @(negedge i_clock);
        i_sync = 0;
    endtask
    // cycles until the next pulse, capped at lim
    task wait_p(input bit fb, input int lim, output int c);
        c = 0;
        do begin
            @(negedge i_clock);
            c++;
        end while (!(fb ? o_fb_pfd_tick : o_ref_pfd_tick) && c < lim);
    endtask
    initial begin
        i_clock = 0;
        forever #20 i_clock = ~i_clock;
    end
    always @(negedge i_clock) cyc <= cyc + 16'h1;
    initial begin
        // about 25k cycles, well beyond the roughly 8k the sequences need
        #1000000;
        n_fail++;
        close_out;
    end
    initial begin
        {i_rst_n, i_reg_wr, i_reg_rd, i_sync, i_vco_output_divider_pd} = 0;
        {i_reg_addr, i_reg_wdata} = 0;
        i_vco_output_divider_ratio = 3'h3;
        repeat (5) @(negedge i_clock);
        i_rst_n = 1;
        chk(o_loop_zero_resistor_ohms === 12'd3250);
        for (k = 0; k < 6; k++) rd(10'h205 + 10'(k), 8'h00);
        for (k = 0; k < 6; k++) wr(10'h205 + 10'(k), 8'hff);
        for (k = 0; k < 6; k++) rd(10'h205 + 10'(k), 8'(msk[k]));
        for (k = 0; k < 8; k++) begin
            wr(10'h205, {k[1:0], k[2:0], k[2:0]});
            repeat (2) @(negedge i_clock);
            chk(o_loop_pole_capacitor_pf === 6'(pf[k]) && o_loop_pole2_code === k[1:0]);
            chk(o_loop_zero_resistor_ohms === 12'(oh[k]));
        end
        for (k = 1; k >= 0; k--) begin
            wr(10'h206, 8'(k));
            repeat (2) @(negedge i_clock);
            chk(o_loop_zero_bypass === k[0]);
        end
        foreach (rc[k]) begin
            wr(10'h207, 8'(rc[k]));
            do_sync;
            wait_p(0, 9000, n);
            wait_p(0, 9000, n);
            chk(n == 2 * (rc[k] < 2 ? 1 : rc[k]));
        end
        // the all-ones write left the feedback divider powered down
        wr(10'h209, 8'h00);
        foreach (fn[k]) begin
            wr(10'h208, 8'(fn[k]));
            i_vco_output_divider_ratio = 3'(fm[k]);
            do_sync;
            wait_p(1, 9000, n);
            wait_p(1, 9000, n);
            chk(n == 4 * (fm[k] > 5 ? 3 : fm[k]) * (fn[k] + 1));
        end
        i_vco_output_divider_ratio = 3'h3;
        wr(10'h208, 8'h00);
        foreach (ph[k]) begin
            wr(10'h209, 8'(ph[k]));
            do_sync;
            wait_p(1, 9000, n);
            if (k == 0) d0 = n;
            chk(n - d0 == 6 * ph[k]);
        end
        wr(10'h209, 8'h40);
        repeat (2) @(negedge i_clock);
        wait_p(1, 200, n);
        chk(o_feedback_divider_pd === 1'b1 && n == 200 && o_fb_pfd_tick === 1'b0);
        wr(10'h209, 8'h00);
        i_vco_output_divider_pd = 1;
        repeat (12) @(negedge i_clock);
        wait_p(1, 200, n);
        chk(n == 200 && o_fb_pfd_tick === 1'b0);
        i_vco_output_divider_pd = 0;
        do_sync;
        wait_p(1, 200, n);
        chk(n < 200);
        close_out;
    end
endmodule // tb_top
